/* File: kpr_pad_master.sv */
// Purpose: keypad controller model, spi master driving the link
// Assumes: mode bits 0x20, 0x08, 0x04 as in the design package
// Notes:   sck moves to the mode's idle level just before ss_b falls, else stands still; mosi flips when released
`timescale 1ns/1ps
module kpr_pad_master (
  // link outputs
  output logic sck_o,
  output logic ss_b_o,
  output logic mosi_o
);
  logic [7:0] b;
  initial begin
    sck_o  = 1'b0;
    ss_b_o = 1'b1;
    mosi_o = 1'b0;
  end
  // ****
  // one frame of n bytes, b0 upwards
  // ****
  task automatic frame(input logic [7:0] m, input logic [7:0] b0,
                       input int n);
    logic idle;
    idle = m[3] ^ m[2];
    #1;  // step off the caller's clock edge
    sck_o = idle;
    #13;
    ss_b_o = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      b = b0 + i[7:0];
      for (int j = 0; j < 8; j++) begin
        mosi_o = m[5] ? b[j] : b[7-j];
        #20;
        sck_o = ~idle;
        #40;
        sck_o = idle;  // sampling edge
        #20;
      end
    end
    ss_b_o = 1'b1;
    mosi_o = ~mosi_o;  // released line holds no valid level
  endtask
endmodule

/* File: kpr_pkg.sv */
// Purpose: shared constants for the keypad spi slave receiver
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   all offsets and ctrl/stat bit positions live here; cfg byte fields are placed in the top level
package kpr_pkg;
  // ********************************
  // register map
  // ********************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_DATA   = 8'h10;
  localparam logic [7:0] ADDR_LEVEL  = 8'h14;
  // ********************************
  // fields
  // ********************************
  localparam int        CTRL_EN_BIT   = 0;
  localparam int        CTRL_GIE_BIT  = 1;
  localparam logic [7:0] MODE_LSB     = 8'h20;
  localparam logic [7:0] MODE_LOWEDGE = 8'h08;
  localparam logic [7:0] MODE_AFTER   = 8'h04;
  localparam logic [7:0] MODE_USED    = 8'h2c;
  localparam int        STAT_PKT_BIT  = 0;
  localparam int        STAT_OVF_BIT  = 1;
  localparam int        NUM_EVT       = 2;
  localparam logic [7:0] PKT_RST      = 8'h04;
  localparam logic [7:0] BUF_RST      = 8'h14;
  localparam logic [1:0] MASK_RST     = 2'h3;
  localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;
endpackage

/* File: kpr_shift.sv */
// Purpose: serial byte assembly from synchronised link levels
// Assumes: sck, ss_b, mosi already synchronised
// Notes:   mode bits decoded one by one
`timescale 1ns/1ps
module kpr_shift (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  // link levels
  input  wire logic       sck_i,
  input  wire logic       ss_b_i,
  input  wire logic       mosi_i,
  // mode
  input  wire logic [7:0] mode_i,
  // byte out
  output logic            byte_vld_o,
  output logic      [7:0] byte_o
);
  logic       sck_d_r;
  logic       sck_d_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       vld_r;
  logic       vld_nxt;
  logic [7:0] out_r;
  logic [7:0] out_nxt;
  logic       rise;
  logic       fall;
  logic       trig;
  logic       lead;
  logic       smp;
  logic [7:0] nb;

  always_comb begin
    rise = sck_i & ~sck_d_r;
    fall = ~sck_i & sck_d_r;
    // trigger edge and sampling point per mode bits
    trig = ((mode_i & kpr_pkg::MODE_LOWEDGE) != 8'h00) ? fall : rise;
    lead = ((mode_i & kpr_pkg::MODE_LOWEDGE) != 8'h00) ? rise : fall;
    smp  = ((mode_i & kpr_pkg::MODE_AFTER) != 8'h00) ? trig : lead;
    if ((mode_i & kpr_pkg::MODE_LSB) != 8'h00) begin
      nb = {mosi_i, sh_r[7:1]};
    end else begin
      nb = {sh_r[6:0], mosi_i};
    end
    sck_d_nxt = sck_i;
    sh_nxt    = sh_r;
    cnt_nxt   = cnt_r;
    vld_nxt   = 1'b0;
    out_nxt   = out_r;
    if (ss_b_i) begin
      cnt_nxt = 3'h0;
    end else if (smp) begin
      sh_nxt  = nb;
      cnt_nxt = cnt_r + 3'h1;
      if (cnt_r == 3'h7) begin
        vld_nxt = 1'b1;
        out_nxt = nb;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_d_r <= 1'b0;
      sh_r    <= 8'h00;
      cnt_r   <= 3'h0;
      vld_r   <= 1'b0;
      out_r   <= 8'h00;
    end else begin
      sck_d_r <= sck_d_nxt;
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      vld_r   <= vld_nxt;
      out_r   <= out_nxt;
    end
  end
  assign byte_vld_o = vld_r;
  assign byte_o     = out_r;
endmodule

/* File: kpr_sync.sv */
// Purpose: two-flop synchroniser for link pins
// Assumes: inputs asynchronous to clock_i
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module kpr_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule

/* File: kpr_top.sv */
// Purpose: receive-only spi slave for keypad bytes, wishbone registers
// Assumes: master drives sck, ss_b, mosi; 125 MHz clock_i
// Notes:   byte buffer, packet interrupt with mask and global enable
// Behaviour
// - port acts as spi slave, external clock
// - four wires; master drives three, device miso
// - interrupt each time packet size reached
// - mode bits choose order, edge, sample point
// - mode is sum of independent option bits
// - enabling port sets pin directions itself
// - per-source enable resets enabled
// - cleared source enable blocks packet interrupt
// - global enable gates all, resets enabled
// - global toggle keeps per-source settings
`timescale 1ns/1ps
module kpr_top #(
  parameter int DEPTH = 256
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // spi link
  input  wire logic        sck_i,
  input  wire logic        ss_b_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // interrupt
  output logic             irq_o
);
  // ********************************
  // state
  // ********************************
  logic [7:0]  mem_r [DEPTH];
  logic        en_r,   en_nxt;
  logic        gie_r,  gie_nxt;
  logic [7:0]  mode_r, mode_nxt;
  logic [7:0]  pkt_r,  pkt_nxt;
  logic [7:0]  bsz_r,  bsz_nxt;
  logic [7:0]  wp_r,   wp_nxt;
  logic [7:0]  rp_r,   rp_nxt;
  logic [8:0]  lvl_r,  lvl_nxt;
  logic [7:0]  pc_r,   pc_nxt;
  logic [1:0]  st_r,   st_nxt;
  logic [1:0]  msk_r,  msk_nxt;
  logic        ack_r,  ack_nxt;
  logic [31:0] rd_r,   rd_nxt;
  logic [2:0]  lnk;
  logic        bvld;
  logic [7:0]  bdat;
  logic        acc, wr, rd, push, pop, full;
  logic [1:0]  evt;

  // ********************************
  // helpers
  // ********************************
  // ring pointer step, wraps at the programmed buffer size
  function automatic logic [7:0] ptr_inc(input logic [7:0] p,
                                         input logic [7:0] sz);
    ptr_inc = (p + 8'h01 >= sz) ? 8'h00 : p + 8'h01;
  endfunction

  // ********************************
  // link sampling
  // ********************************
  kpr_sync #(.W(3)) u_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .d_i     ({sck_i, ss_b_i, mosi_i}),
    .q_o     (lnk)
  );

  kpr_shift u_shift (
    .clock_i    (clock_i),
    .rst_b_i    (rst_b_i),
    .sck_i      (lnk[2]),
    .ss_b_i     (lnk[1] | ~en_r),
    .mosi_i     (lnk[0]),
    .mode_i     (mode_r),
    .byte_vld_o (bvld),
    .byte_o     (bdat)
  );

  // receive-only: miso released unless port enabled and ss_b low, then held low
  assign miso_o    = 1'b0;
  assign miso_oe_o = en_r & ~lnk[1];

  // ********************************
  // buffer and events
  // ********************************
  always_comb begin
    acc  = wb_cyc_i & wb_stb_i & ~ack_r;
    wr   = acc & wb_we_i;
    rd   = acc & ~wb_we_i;
    full = ({1'b0, lvl_r[7:0]} >= {1'b0, bsz_r}) | lvl_r[8];
    push = bvld & ~full;
    pop  = rd & (wb_adr_i == kpr_pkg::ADDR_DATA) & (lvl_r != 9'h000);
    evt  = 2'h0;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    pc_nxt  = pc_r;
    if (push) begin
      wp_nxt = ptr_inc(wp_r, bsz_r);
      if (pc_r + 8'h01 >= pkt_r) begin
        pc_nxt = 8'h00;
        evt[kpr_pkg::STAT_PKT_BIT] = 1'b1;
      end else begin
        pc_nxt = pc_r + 8'h01;
      end
    end
    if (bvld & full) begin
      evt[kpr_pkg::STAT_OVF_BIT] = 1'b1;
    end
    if (pop) begin
      rp_nxt = ptr_inc(rp_r, bsz_r);
    end
    lvl_nxt = lvl_r + {8'h00, push} - {8'h00, pop};
  end

  // ********************************
  // register file
  // ********************************
  always_comb begin
    en_nxt   = en_r;
    gie_nxt  = gie_r;
    mode_nxt = mode_r;
    pkt_nxt  = pkt_r;
    bsz_nxt  = bsz_r;
    msk_nxt  = msk_r;
    st_nxt   = st_r;
    ack_nxt  = acc;
    rd_nxt   = rd_r;
    if (wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        kpr_pkg::ADDR_CTRL: begin
          en_nxt  = wb_dat_i[kpr_pkg::CTRL_EN_BIT];
          gie_nxt = wb_dat_i[kpr_pkg::CTRL_GIE_BIT];
        end
        kpr_pkg::ADDR_STAT: st_nxt = st_r & ~wb_dat_i[1:0];
        kpr_pkg::ADDR_MASK: msk_nxt = wb_dat_i[1:0];
        default: ;
      endcase
    end
    if (wr && (wb_adr_i == kpr_pkg::ADDR_CFG)) begin
      if (wb_sel_i[0]) mode_nxt = wb_dat_i[7:0] & kpr_pkg::MODE_USED;
      if (wb_sel_i[1] && wb_dat_i[15:8] != 8'h00) pkt_nxt = wb_dat_i[15:8];
      if (wb_sel_i[2] && wb_dat_i[23:16] != 8'h00) bsz_nxt = wb_dat_i[23:16];
    end
    st_nxt = st_nxt | evt; // set wins over clear
    if (rd) begin
      unique case (wb_adr_i)
        kpr_pkg::ADDR_CTRL:  rd_nxt = {30'h0, gie_r, en_r};
        kpr_pkg::ADDR_CFG:   rd_nxt = {8'h00, bsz_r, pkt_r, mode_r};
        kpr_pkg::ADDR_STAT:  rd_nxt = {30'h0, st_r};
        kpr_pkg::ADDR_MASK:  rd_nxt = {30'h0, msk_r};
        kpr_pkg::ADDR_DATA:  rd_nxt = {24'h0, mem_r[rp_r]};
        kpr_pkg::ADDR_LEVEL: rd_nxt = {23'h0, lvl_r};
        default:             rd_nxt = kpr_pkg::BUS_ERR_DATA;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wp_r] <= bdat;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_r   <= 1'b0;
      gie_r  <= 1'b1;
      mode_r <= 8'h00;
      pkt_r  <= kpr_pkg::PKT_RST;
      bsz_r  <= kpr_pkg::BUF_RST;
      msk_r  <= kpr_pkg::MASK_RST;
      st_r   <= 2'h0;
      wp_r   <= 8'h00;
      rp_r   <= 8'h00;
      lvl_r  <= 9'h000;
      pc_r   <= 8'h00;
      ack_r  <= 1'b0;
      rd_r   <= 32'h0000_0000;
    end else begin
      en_r   <= en_nxt;
      gie_r  <= gie_nxt;
      mode_r <= mode_nxt;
      pkt_r  <= pkt_nxt;
      bsz_r  <= bsz_nxt;
      msk_r  <= msk_nxt;
      st_r   <= st_nxt;
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      lvl_r  <= lvl_nxt;
      pc_r   <= pc_nxt;
      ack_r  <= ack_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;
  assign irq_o    = gie_r & |(st_r & msk_r);

  // ********************************
  // checks
  // ********************************
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  a_ack_one_cycle: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not single cycle");

  a_pkt_sets_stat: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    evt[kpr_pkg::STAT_PKT_BIT] |=> st_r[kpr_pkg::STAT_PKT_BIT])
    else $error("packet event lost");

  a_irq_gated: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !gie_r |-> !irq_o)
    else $error("irq with global off");

  a_irq_masked: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (st_r & msk_r) == 2'h0 |-> !irq_o)
    else $error("masked irq seen");

  a_full_drop: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bvld && full && !pop |=> lvl_r == $past(lvl_r))
    else $error("write into full buffer");

  a_mode_clean: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (mode_r & ~kpr_pkg::MODE_USED) == 8'h00)
    else $error("undefined mode bit kept");

  a_mask_keep: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $changed(gie_r) |-> $stable(msk_r))
    else $error("mask changed with gie");

  a_level_bound: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    lvl_r <= {1'b0, bsz_r} || $changed(bsz_r))
    else $error("level above buffer size");

  a_miso_idle: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !en_r |-> !miso_oe_o)
    else $error("miso driven while off");

  sequence s_byte_in;
    bvld && !full;
  endsequence

  a_push_level: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    s_byte_in ##0 !pop |=> lvl_r == $past(lvl_r) + 9'h001)
    else $error("accepted byte not counted");

  a_pop_level: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    pop && !push |=> lvl_r == $past(lvl_r) - 9'h001)
    else $error("popped byte not counted");

  a_drop_keeps_wp: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    bvld && full |=> wp_r == $past(wp_r))
    else $error("dropped byte moved write pointer");

  a_ovf_sets_stat: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    evt[kpr_pkg::STAT_OVF_BIT] |=> st_r[kpr_pkg::STAT_OVF_BIT])
    else $error("overflow event lost");

  a_stat_clear: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    wr && wb_sel_i[0] && wb_adr_i == kpr_pkg::ADDR_STAT
      && wb_dat_i[kpr_pkg::STAT_PKT_BIT] && !evt[kpr_pkg::STAT_PKT_BIT]
    |=> !st_r[kpr_pkg::STAT_PKT_BIT])
    else $error("status bit not cleared");
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench for the keypad spi receiver
// Assumes: wishbone ack one cycle after request, pkt 4 buf 20 at reset
// Notes:   link clock 80 ns from the master model
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module testbench;
  logic        clock_i;
  logic        rst_b_i;
  logic        cyc, stb, we;
  logic [7:0]  adr;
  logic [31:0] dat, q;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, sck, ss_b, mosi, miso_o, miso_oe_o, irq_o;
  int          n_errors, checked;
  kpr_top u_kpr_top (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sck_i(sck), .ss_b_i(ss_b), .mosi_i(mosi),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .irq_o(irq_o));
  kpr_pad_master u_kpr_pad_master (.sck_o(sck), .ss_b_o(ss_b),
    .mosi_o(mosi));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // ****
  // bus and helpers
  // ****
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clock_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) `CHK(k, 0)
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(irq_o, e)
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic drain(input logic [7:0] b0, input int n);
    for (int i = 0; i < n; i++)
      rd_chk(kpr_pkg::ADDR_DATA, {24'h0, b0 + i[7:0]});
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd_chk(kpr_pkg::ADDR_CTRL, 32'h0000_0002);
    rd_chk(kpr_pkg::ADDR_CFG, 32'h0014_0400);
    rd_chk(kpr_pkg::ADDR_MASK, 32'h0000_0003);
    rd_chk(kpr_pkg::ADDR_STAT, 32'h0);
    rd_chk(8'h20, 32'h0);
    u_kpr_pad_master.frame(8'h00, 8'h55, 1);
    rd_chk(kpr_pkg::ADDR_LEVEL, 32'h0);
    wb(1'b1, kpr_pkg::ADDR_CTRL, 32'h3);
  endtask
  task automatic t_modes;
    logic [7:0] m;
    for (int k = 0; k < 8; k++) begin
      m = {2'h0, k[2], 1'b0, k[1:0], 2'h0} | (k[0] ? 8'hd3 : 8'h00);
      wb(1'b1, kpr_pkg::ADDR_CFG, {16'h1404, m});
      fork
        u_kpr_pad_master.frame(m, {k[3:0], 4'h9}, 4);
        begin
          #300;
          `CHK({miso_oe_o, miso_o}, 2'b10)
        end
      join
      chk_irq(1'b1);
      rd_chk(kpr_pkg::ADDR_LEVEL, 32'h4);
      drain({k[3:0], 4'h9}, 4);
      rd_chk(kpr_pkg::ADDR_STAT, 32'h1);
      wb(1'b1, kpr_pkg::ADDR_STAT, 32'h1);
      chk_irq(1'b0);
    end
  endtask
  task automatic t_gate;
    wb(1'b1, kpr_pkg::ADDR_CFG, 32'h0014_0400);
    wb(1'b1, kpr_pkg::ADDR_MASK, 32'h0);
    u_kpr_pad_master.frame(8'h00, 8'hc0, 4);
    chk_irq(1'b0);
    rd_chk(kpr_pkg::ADDR_STAT, 32'h1);
    wb(1'b1, kpr_pkg::ADDR_MASK, 32'h1);
    wb(1'b1, kpr_pkg::ADDR_CTRL, 32'h1);
    chk_irq(1'b0);
    wb(1'b1, kpr_pkg::ADDR_CTRL, 32'h3);
    chk_irq(1'b1);
    rd_chk(kpr_pkg::ADDR_MASK, 32'h1);
    drain(8'hc0, 4);
    wb(1'b1, kpr_pkg::ADDR_STAT, 32'h3);
    chk_irq(1'b0);
  endtask
  task automatic t_ovf;
    wb(1'b1, kpr_pkg::ADDR_CFG, 32'h0003_0200);
    u_kpr_pad_master.frame(8'h00, 8'h70, 5);
    rd_chk(kpr_pkg::ADDR_LEVEL, 32'h3);
    rd_chk(kpr_pkg::ADDR_STAT, 32'h3);
    drain(8'h70, 3);
  endtask
  // ****
  // run control
  // ****
  task automatic final_report;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    final_report;
  end
  initial begin
    n_errors = 0;
    checked  = 0;
    rst_b_i  = 1'b0;
    {cyc, stb, we, adr, dat} = '0;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_modes;
    t_gate;
    t_ovf;
    final_report;
  end
endmodule
